// >>> rtl/rcss_top.sv
// Reset cause detection and power-up time-out sequencer
//
// Behaviour
// - Distinguish seven reset causes
// - Preserved registers never touched by reset
// - Resets load reset state; watchdog wake does not
// - Time-out and power-down flags record cause
// - Filter glitches off the master clear pin
// - Watchdog never drives the master clear pin
// - Supply rise generates internal power-on reset
// - Power-up timer holds core after power-on
// - Power-up timer counts its own RC oscillator
// - Option bypasses the power-up timer
// - Oscillator start holds core 1024 input cycles
// - Oscillator start only crystal modes, power-on/wake
// - Option enables brown-out reset
// - Brown-out trips after minimum low duration
// - Hold until supply good, then power-up timer
// - Brown-out during power-up timer restarts it
// - Stages run power-on, power-up, oscillator start
// - RC mode without timer releases immediately
// - Time-outs ignore pin; pin release runs at once
// - Pin reset while running keeps both flags
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module rcss_top
	import rcss_pkg::*;
#(
	parameter int RC_OSC_KHZ = `RCSS_RC_OSC_KHZ,
	parameter int POWER_UP_TIMER_TICKS = `RCSS_POWER_UP_TIMER_TIME_US * RC_OSC_KHZ / 1000,
	parameter int OST_CYCLES = `RCSS_OST_CYCLES,
	parameter int BOR_MIN_CYCLES = `RCSS_BOR_MIN_CYCLES,
	parameter int MASTER_CLEAR_PIN_FILT_CYCLES = `RCSS_MASTER_CLEAR_PIN_FILT_CYCLES
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Analog detector and pin inputs, asynchronous
	input wire logic supply_ok_in,
	input wire logic brown_low_in,
	input wire logic master_clear_pin_n_in,
	input wire logic watchdog_timer_event_in,
	input wire logic power_up_timer_rc_osc_in,
	input wire logic oscillator_input_in,
	// Same-clock inputs
	input wire logic interrupt_wake_in,
	input wire logic [1:0] osc_mode_in,
	input wire logic power_up_timer_en_n_in,
	input wire logic brown_out_enable_option_in,
	// Register port
	input wire logic [`RCSS_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Reset and status outputs
	output logic core_reset_out,
	output logic regs_reset_out,
	output logic wake_out,
	output logic [2:0] reset_cause_out,
	output logic timeout_flag_out,
	output logic power_down_flag_out,
	output logic sleep_out,
	// Master clear pin drive, open drain
	output logic master_clear_pin_out,
	output logic master_clear_pin_oe_out
);

	localparam logic [`RCSS_CNT_W-1:0] POWER_UP_TIMER_LAST =
		`RCSS_CNT_W'(POWER_UP_TIMER_TICKS - 1);
	localparam logic [`RCSS_CNT_W-1:0] OST_LAST =
		`RCSS_CNT_W'(OST_CYCLES - 1);
	localparam logic [`RCSS_FILT_W-1:0] BOR_LAST =
		`RCSS_FILT_W'(BOR_MIN_CYCLES - 1);
	localparam logic [`RCSS_FILT_W-1:0] FILT_LAST =
		`RCSS_FILT_W'(MASTER_CLEAR_PIN_FILT_CYCLES);

	rcss_regs_t r_reg;
	rcss_regs_t r_next;

	logic bor_low, xtal, power_up_timer_on, wdt_rise, rc_rise, osc_rise;
	logic bor_trip, master_clear_pin_evt, hw_por, hw_bor;

	always_comb
	begin
		r_next = r_reg;
		xtal = rcss_osc_t'(osc_mode_in) != RCSS_OSC_RC;
		power_up_timer_on = !power_up_timer_en_n_in;
		// Stage [0] is read only by stage [1]
		r_next.sup_s = {r_reg.sup_s[1:0], supply_ok_in};
		r_next.bl_s = {r_reg.bl_s[1:0], brown_low_in};
		r_next.mc_s = {r_reg.mc_s[1:0], master_clear_pin_n_in};
		r_next.wd_s = {r_reg.wd_s[1:0], watchdog_timer_event_in};
		r_next.rc_s = {r_reg.rc_s[1:0], power_up_timer_rc_osc_in};
		r_next.os_s = {r_reg.os_s[1:0], oscillator_input_in};
		wdt_rise = r_reg.wd_s[1] && !r_reg.wd_s[2];
		rc_rise = r_reg.rc_s[1] && !r_reg.rc_s[2];
		osc_rise = r_reg.os_s[1] && !r_reg.os_s[2];
		bor_low = r_reg.bl_s[1] && brown_out_enable_option_in;
		r_next.wake = 1'b0;
		hw_por = 1'b0;
		hw_bor = 1'b0;

		// Low must persist the whole filter window to count
		if (!r_reg.mc_s[1])
		begin
			if (r_reg.master_clear_pin_cnt != FILT_LAST)
				r_next.master_clear_pin_cnt = r_reg.master_clear_pin_cnt + 1'b1;
			else
				r_next.master_clear_pin_low = 1'b1;
		end
		else
		begin
			r_next.master_clear_pin_cnt = '0;
			r_next.master_clear_pin_low = 1'b0;
		end
		master_clear_pin_evt = r_next.master_clear_pin_low && !r_reg.master_clear_pin_low;

		// Shorter dips may pass without a reset; trip fires once per dip
		bor_trip = bor_low && r_reg.bl_cnt == BOR_LAST - 1'b1;
		if (bor_low)
		begin
			if (r_reg.bl_cnt != BOR_LAST)
				r_next.bl_cnt = r_reg.bl_cnt + 1'b1;
		end
		else
			r_next.bl_cnt = '0;

		if (!r_reg.sup_s[1])
		begin
			// Supply absent: held as power-on until it rises
			hw_por = 1'b1;
			r_next.state = RCSS_HOLD;
			r_next.cause = RCSS_C_POR;
			r_next.to = `RCSS_TO_RESET;
			r_next.pd = `RCSS_PD_RESET;
			r_next.sleep = 1'b0;
			r_next.rst_class = 1'b1;
			r_next.power_up_timer_pend = power_up_timer_on;
			r_next.ost_pend = xtal;
		end
		else if (bor_trip)
		begin
			hw_bor = 1'b1;
			r_next.state = RCSS_HOLD;
			r_next.cause = RCSS_C_BOR;
			r_next.to = 1'b1;
			r_next.pd = 1'b1;
			r_next.sleep = 1'b0;
			r_next.rst_class = 1'b1;
			r_next.power_up_timer_pend = power_up_timer_on;
			r_next.ost_pend = 1'b0;
		end
		else if (r_reg.state == RCSS_RUN && master_clear_pin_evt)
		begin
			// Pin reset after start-up; timers are not rerun
			r_next.rst_class = 1'b1;
			r_next.power_up_timer_pend = 1'b0;
			r_next.ost_pend = 1'b0;
			r_next.state = RCSS_HOLD;
			r_next.sleep = 1'b0;
			if (r_reg.sleep)
			begin
				r_next.cause = RCSS_C_MASTER_CLEAR_PIN_SLEEP;
				r_next.to = 1'b1;
				r_next.pd = 1'b0;
			end
			else
				r_next.cause = RCSS_C_MASTER_CLEAR_PIN_RUN;
		end
		else if (r_reg.state == RCSS_RUN && wdt_rise)
		begin
			r_next.state = RCSS_HOLD;
			r_next.to = 1'b0;
			r_next.power_up_timer_pend = 1'b0;
			r_next.sleep = 1'b0;
			if (r_reg.sleep)
			begin
				// Wake resumes; register contents stay
				r_next.cause = RCSS_C_WDT_WAKE;
				r_next.pd = 1'b0;
				r_next.rst_class = 1'b0;
				r_next.ost_pend = xtal;
				r_next.wake = 1'b1;
			end
			else
			begin
				r_next.cause = RCSS_C_WDT_RESET;
				r_next.pd = 1'b1;
				r_next.rst_class = 1'b1;
				r_next.ost_pend = 1'b0;
			end
		end
		else if (r_reg.state == RCSS_RUN && r_reg.sleep && interrupt_wake_in)
		begin
			r_next.state = RCSS_HOLD;
			r_next.cause = RCSS_C_INT_WAKE;
			r_next.to = 1'b1;
			r_next.pd = 1'b0;
			r_next.sleep = 1'b0;
			r_next.rst_class = 1'b0;
			r_next.power_up_timer_pend = 1'b0;
			r_next.ost_pend = xtal;
			r_next.wake = 1'b1;
		end
		else
		begin
			// Pin is ignored here so time-outs run from power-on
			case (r_reg.state)
				RCSS_HOLD:
				begin
					if (!bor_low)
					begin
						r_next.power_up_timer_cnt = '0;
						r_next.ost_cnt = '0;
						if (r_reg.power_up_timer_pend)
							r_next.state = RCSS_POWER_UP_TIMER;
						else if (r_reg.ost_pend)
							r_next.state = RCSS_OST;
						else
							r_next.state = RCSS_RUN;
					end
				end
				RCSS_POWER_UP_TIMER:
				begin
					if (bor_low)
						r_next.state = RCSS_HOLD;
					else if (rc_rise)
					begin
						if (r_reg.power_up_timer_cnt == POWER_UP_TIMER_LAST)
						begin
							r_next.power_up_timer_pend = 1'b0;
							r_next.state = r_reg.ost_pend ? RCSS_OST : RCSS_RUN;
						end
						else
							r_next.power_up_timer_cnt = r_reg.power_up_timer_cnt + 1'b1;
					end
				end
				RCSS_OST:
				begin
					if (osc_rise)
					begin
						if (r_reg.ost_cnt == OST_LAST)
						begin
							r_next.ost_pend = 1'b0;
							r_next.state = RCSS_RUN;
						end
						else
							r_next.ost_cnt = r_reg.ost_cnt + 1'b1;
					end
				end
				default:
				begin
					r_next.rst_class = 1'b0;
				end
			endcase
		end

		// Register port; hardware clears of status bits win
		r_next.rd = '0;
		if (reg_wr_in)
		begin
			if (reg_addr_in == `RCSS_REG_PWR)
			begin
				if (!hw_por)
					r_next.por_st = reg_wdata_in[`RCSS_PWR_POR_BIT];
				if (!hw_bor)
					r_next.bor_st = reg_wdata_in[`RCSS_PWR_BOR_BIT];
			end
			else if (reg_addr_in == `RCSS_REG_CTRL)
			begin
				if (reg_wdata_in[`RCSS_CTRL_SLEEP_BIT] &&
					r_reg.state == RCSS_RUN && r_next.state == RCSS_RUN)
				begin
					r_next.sleep = 1'b1;
					r_next.to = 1'b1;
					r_next.pd = 1'b0;
				end
			end
			else if (reg_addr_in == `RCSS_REG_KEEP)
				r_next.keep = reg_wdata_in[7:0];
		end
		else if (reg_rd_in)
		begin
			if (reg_addr_in == `RCSS_REG_STATUS)
			begin
				r_next.rd[`RCSS_ST_CAUSE_LSB +: 3] = r_reg.cause;
				r_next.rd[`RCSS_ST_TO_BIT] = r_reg.to;
				r_next.rd[`RCSS_ST_PD_BIT] = r_reg.pd;
				r_next.rd[`RCSS_ST_STATE_LSB +: 2] = r_reg.state;
				r_next.rd[`RCSS_ST_HOLD_BIT] = r_reg.core_rst;
			end
			else if (reg_addr_in == `RCSS_REG_PWR)
			begin
				r_next.rd[`RCSS_PWR_POR_BIT] = r_reg.por_st;
				r_next.rd[`RCSS_PWR_BOR_BIT] = r_reg.bor_st;
			end
			else if (reg_addr_in == `RCSS_REG_CTRL)
				r_next.rd[`RCSS_CTRL_SLEEP_BIT] = r_reg.sleep;
			else if (reg_addr_in == `RCSS_REG_KEEP)
				r_next.rd[7:0] = r_reg.keep;
		end
		if (hw_por)
			r_next.por_st = 1'b0;
		if (hw_bor)
			r_next.bor_st = 1'b0;

		if (reset_in)
		begin
			r_next = '0;
			// Preserved contents survive every reset
			r_next.keep = r_reg.keep;
			r_next.state = RCSS_HOLD;
			r_next.cause = RCSS_C_POR;
			r_next.to = `RCSS_TO_RESET;
			r_next.pd = `RCSS_PD_RESET;
			r_next.por_st = `RCSS_POR_ST_RESET;
			r_next.bor_st = `RCSS_BOR_ST_RESET;
			// Pin idles high, so no false filter start
			r_next.mc_s = '1;
			r_next.power_up_timer_pend = 1'b1;
			r_next.ost_pend = 1'b1;
			r_next.rst_class = 1'b1;
		end
		r_next.core_rst = r_next.state != RCSS_RUN || r_next.master_clear_pin_low;
		r_next.regs_rst = (r_next.rst_class && r_next.state != RCSS_RUN) ||
			r_next.master_clear_pin_low;
	end

	always_ff @(posedge clk_in)
	begin
		r_reg <= r_next;
	end

	assign reg_rdata_out = r_reg.rd;
	assign core_reset_out = r_reg.core_rst;
	assign regs_reset_out = r_reg.regs_rst;
	assign wake_out = r_reg.wake;
	assign reset_cause_out = r_reg.cause;
	assign timeout_flag_out = r_reg.to;
	assign power_down_flag_out = r_reg.pd;
	assign sleep_out = r_reg.sleep;
	// Watchdog resets are internal; the pin is never pulled
	assign master_clear_pin_out = 1'b0;
	assign master_clear_pin_oe_out = 1'b0;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	AST_PIN_NEVER_DRIVEN: assert property (
		!master_clear_pin_oe_out)
		else $error("master clear pin driven");
	AST_CORE_HELD: assert property (
		r_reg.state != RCSS_RUN |-> core_reset_out)
		else $error("core released before run");
	AST_PIN_RUN_FLAGS: assert property (
		$changed(r_reg.cause) && r_reg.cause == RCSS_C_MASTER_CLEAR_PIN_RUN
		|-> $stable(timeout_flag_out) && $stable(power_down_flag_out))
		else $error("pin reset changed flags");
	AST_WAKE_NO_REGRST: assert property (
		wake_out && !r_reg.master_clear_pin_low |-> !regs_reset_out)
		else $error("wake reset registers");
	AST_KEEP_STABLE: assert property (
		@(posedge clk_in) disable iff (1'b0)
		!(reg_wr_in && !reset_in && reg_addr_in == `RCSS_REG_KEEP)
		|=> r_reg.keep === $past(r_reg.keep))
		else $error("preserved register changed without a write");
	AST_RC_NO_OST: assert property (
		$rose(r_reg.state == RCSS_OST) |-> $past(xtal))
		else $error("oscillator start in RC mode");
	AST_BOR_RESTART: assert property (
		r_reg.state == RCSS_POWER_UP_TIMER && bor_low && r_reg.sup_s[1]
		|=> r_reg.state == RCSS_HOLD ##1 r_reg.power_up_timer_cnt == '0 ||
			r_reg.state == RCSS_HOLD)
		else $error("power-up timer not restarted");
	AST_OST_LEN: assert property (
		r_reg.state == RCSS_OST ##1 r_reg.state == RCSS_RUN
		|-> $past(r_reg.ost_cnt) == OST_LAST)
		else $error("oscillator start count wrong");
	AST_POWER_UP_TIMER_LEN: assert property (
		r_reg.state == RCSS_POWER_UP_TIMER ##1 r_reg.state inside {RCSS_OST, RCSS_RUN}
		|-> $past(r_reg.power_up_timer_cnt) == POWER_UP_TIMER_LAST)
		else $error("power-up count wrong");
	AST_FILTER: assert property (
		$rose(r_reg.master_clear_pin_low) |-> $past(r_reg.master_clear_pin_cnt) == FILT_LAST)
		else $error("pin glitch passed filter");

	COV_POWER_UP_TIMER_DONE: cover property (
		r_reg.state == RCSS_POWER_UP_TIMER ##1 r_reg.state == RCSS_OST);
	COV_WDT_WAKE: cover property (wake_out && r_reg.cause == RCSS_C_WDT_WAKE);
	COV_BOR: cover property ($rose(r_reg.cause == RCSS_C_BOR));

endmodule

// >>> include/rcss_params.svh
// Constants for the reset cause and start-up sequencer
`ifndef RCSS_PARAMS_SVH
`define RCSS_PARAMS_SVH

// Register byte offsets on the plain register port
`define RCSS_ADDR_W 4
`define RCSS_REG_STATUS 4'h0
`define RCSS_REG_PWR 4'h4
`define RCSS_REG_CTRL 4'h8
`define RCSS_REG_KEEP 4'hC

// Field positions
`define RCSS_ST_CAUSE_LSB 0
`define RCSS_ST_TO_BIT 3
`define RCSS_ST_PD_BIT 4
`define RCSS_ST_STATE_LSB 5
`define RCSS_ST_HOLD_BIT 7
`define RCSS_PWR_POR_BIT 0
`define RCSS_PWR_BOR_BIT 1
`define RCSS_CTRL_SLEEP_BIT 0

// Reset values
`define RCSS_TO_RESET 1'h1
`define RCSS_PD_RESET 1'h1
`define RCSS_POR_ST_RESET 1'h0
`define RCSS_BOR_ST_RESET 1'h1

// Timing: power-up time in microseconds, 72 ms
`define RCSS_POWER_UP_TIMER_TIME_US 32'h0001_1940
`define RCSS_RC_OSC_KHZ 32'h0000_0064
`define RCSS_OST_CYCLES 32'h0000_0400
`define RCSS_BOR_MIN_CYCLES 32'h0000_0019
`define RCSS_MASTER_CLEAR_PIN_FILT_CYCLES 32'h0000_0008
`define RCSS_CNT_W 24
`define RCSS_FILT_W 8

`endif

// >>> include/rcss_pkg.sv
// Types for the reset cause and start-up sequencer
`include "rcss_params.svh"
package rcss_pkg;

	// Gray codes along hold, power-up, oscillator start, run
	typedef enum logic [1:0] {
		RCSS_HOLD = 2'h0,
		RCSS_POWER_UP_TIMER = 2'h1,
		RCSS_OST = 2'h3,
		RCSS_RUN = 2'h2
	} rcss_state_t;

	typedef enum logic [2:0] {
		RCSS_C_POR = 3'h0,
		RCSS_C_MASTER_CLEAR_PIN_RUN = 3'h1,
		RCSS_C_MASTER_CLEAR_PIN_SLEEP = 3'h2,
		RCSS_C_WDT_RESET = 3'h3,
		RCSS_C_WDT_WAKE = 3'h4,
		RCSS_C_BOR = 3'h5,
		RCSS_C_INT_WAKE = 3'h6
	} rcss_cause_t;

	typedef enum logic [1:0] {
		RCSS_OSC_LP = 2'h0,
		RCSS_OSC_XT = 2'h1,
		RCSS_OSC_HS = 2'h2,
		RCSS_OSC_RC = 2'h3
	} rcss_osc_t;

	typedef struct packed {
		rcss_state_t state;
		rcss_cause_t cause;
		logic to;
		logic pd;
		logic sleep;
		logic por_st;
		logic bor_st;
		logic [7:0] keep;
		logic [31:0] rd;
		logic [2:0] sup_s;
		logic [2:0] bl_s;
		logic [2:0] mc_s;
		logic [2:0] wd_s;
		logic [2:0] rc_s;
		logic [2:0] os_s;
		logic [`RCSS_FILT_W-1:0] master_clear_pin_cnt;
		logic master_clear_pin_low;
		logic [`RCSS_FILT_W-1:0] bl_cnt;
		logic [`RCSS_CNT_W-1:0] power_up_timer_cnt;
		logic [`RCSS_CNT_W-1:0] ost_cnt;
		logic power_up_timer_pend;
		logic ost_pend;
		logic rst_class;
		logic regs_rst;
		logic core_rst;
		logic wake;
	} rcss_regs_t;

endpackage

// >>> test/rcss_partner.sv
// Far-side model: supply detectors, reset pin and both oscillators
`timescale 1ns/1ps
module rcss_partner
(
	// Requests from the bench
	input wire logic supply_req_in,
	input wire logic brown_req_in,
	input wire logic pin_low_req_in,
	// Lines into the sequencer
	output logic supply_ok_out,
	output logic brown_low_out,
	output logic pin_n_out,
	output logic rc_osc_out,
	output logic osc_out
);
	// Pin has a pull-up, so it is high unless pulled down
	assign pin_n_out = !pin_low_req_in;
	assign supply_ok_out = supply_req_in;
	assign brown_low_out = brown_req_in;
	// Free running, unrelated in phase to the core clock
	initial rc_osc_out = 1'b0;
	always #25 rc_osc_out = !rc_osc_out;
	initial osc_out = 1'b0;
	always #7.3 osc_out = !osc_out;
endmodule

// >>> test/rcss_top_tb.sv
// Self-checking bench for the reset cause and start-up sequencer
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
	miscompares++; $display("Error %s exp %h got %h", n, e, a); end end
module rcss_top_tb;
	import rcss_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic sup = 1'b1;
	logic brown = 1'b0;
	logic pin_low = 1'b1;
	logic wd = 1'b0;
	logic iwake = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] seed = 32'h0000_0027;
	logic [1:0] osc_mode = 2'h1;
	logic power_up_timer_en_n = 1'b0;
	logic bor_en = 1'b1;
	logic [31:0] rdata, rv;
	logic sup_ok, brown_low, pin_n, rc_osc, osc;
	logic core_rst, regs_rst, wake, to_f, pd_f, slp, mc, mc_oe;
	logic [2:0] cause, m_cause;
	logic m_to, m_pd;
	logic [7:0] m_keep;
	logic regs_seen, wake_seen;
	int miscompares = 0;
	int check_count = 0;
	int rc_seen = 0;
	int osc_seen = 0;

	always #2 clk_in = !clk_in;

	rcss_partner rcss_partner_inst (.supply_req_in(sup),
		.brown_req_in(brown), .pin_low_req_in(pin_low),
		.supply_ok_out(sup_ok), .brown_low_out(brown_low),
		.pin_n_out(pin_n), .rc_osc_out(rc_osc), .osc_out(osc));

	// Timer kept on whenever brown-out is on
	rcss_top #(.POWER_UP_TIMER_TICKS(8), .OST_CYCLES(4)) rcss_top_inst (
		.clk_in(clk_in), .reset_in(reset_in), .supply_ok_in(sup_ok),
		.brown_low_in(brown_low), .master_clear_pin_n_in(pin_n),
		.watchdog_timer_event_in(wd), .power_up_timer_rc_osc_in(rc_osc),
		.oscillator_input_in(osc), .interrupt_wake_in(iwake),
		.osc_mode_in(osc_mode), .power_up_timer_en_n_in(power_up_timer_en_n),
		.brown_out_enable_option_in(bor_en), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .core_reset_out(core_rst),
		.regs_reset_out(regs_rst), .wake_out(wake),
		.reset_cause_out(cause), .timeout_flag_out(to_f),
		.power_down_flag_out(pd_f), .sleep_out(slp),
		.master_clear_pin_out(mc), .master_clear_pin_oe_out(mc_oe));

	always @(posedge rc_osc)
		if (core_rst === 1'b1)
			rc_seen++;
	always @(posedge osc)
		if (core_rst === 1'b1)
			osc_seen++;
	always @(posedge clk_in)
	begin
		if (regs_rst === 1'b1)
			regs_seen = 1'b1;
		if (wake === 1'b1)
			wake_seen = 1'b1;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask

	task automatic wait_run;
		int k;
		k = 0;
		while (core_rst !== 1'b0 && k < 3000)
		begin
			@(posedge clk_in);
			#1;
			k++;
		end
		if (k == 3000)
		begin
			miscompares++;
			test_done;
		end
		else
			cycles(4);
	endtask

	task automatic check_all;
		rd_reg(4'h0);
		`CHK("status", {24'h0, 3'h2, m_pd, m_to, m_cause}, rv)
		`CHK("cause", m_cause, cause)
		`CHK("timeout", m_to, to_f)
		`CHK("powerdown", m_pd, pd_f)
		`CHK("pin_oe", 1'b0, mc_oe)
		`CHK("pin_drive", 1'b0, mc)
		rd_reg(4'hC);
		`CHK("keep", {24'h0, m_keep}, rv)
	endtask

	initial
	begin
		regs_seen = 1'b0;
		wake_seen = 1'b0;
		m_keep = 8'h00;
		cycles(3);
		reset_in <= 1'b0;
		// Pin held low all through power-up; timers run regardless
		cycles(400);
		`CHK("held", 1'b1, core_rst)
		pin_low <= 1'b0;
		cycles(14);
		`CHK("release", 1'b0, core_rst)
		`CHK("power_up_timer_ran", 1'b1, rc_seen >= 8)
		rd_reg(4'h4);
		`CHK("pwr", 32'h0000_0002, rv)
		rd_reg(4'h2);
		`CHK("unmapped", 32'h0000_0000, rv)
		wr_reg(4'hC, 32'h0000_00A5);
		m_keep = 8'hA5;
		{m_cause, m_to, m_pd} = {3'h0, 1'b1, 1'b1};
		check_all;
		// Short glitch on the pin must be ignored
		pin_low <= 1'b1;
		cycles(3);
		pin_low <= 1'b0;
		cycles(10);
		`CHK("glitch", 1'b0, core_rst)
		check_all;
		// Pin run, watchdog run, pin asleep, watchdog wake, interrupt wake
		for (int k = 0; k < 5; k++)
		begin
			seed = xs(seed);
			m_keep = seed[7:0];
			wr_reg(4'hC, seed);
			if (k >= 2)
			begin
				wr_reg(4'h8, 32'h0000_0001);
				{m_to, m_pd} = 2'b10;
				cycles(2);
				`CHK("sleep", 1'b1, slp)
			end
			regs_seen = 1'b0;
			wake_seen = 1'b0;
			osc_seen = 0;
			if (k == 0 || k == 2)
				pin_low <= 1'b1;
			else if (k == 4)
				iwake <= 1'b1;
			else
				wd <= 1'b1;
			cycles(20);
			{pin_low, iwake, wd} <= 3'b000;
			cycles(4);
			wait_run;
			case (k)
				0: m_cause = 3'h1;
				1: {m_cause, m_to, m_pd} = {3'h3, 1'b0, 1'b1};
				2: m_cause = 3'h2;
				3: {m_cause, m_to, m_pd} = {3'h4, 1'b0, 1'b0};
				default: m_cause = 3'h6;
			endcase
			`CHK("regs_reset", k < 3, regs_seen)
			`CHK("wake", k >= 3, wake_seen)
			if (k >= 3)
				`CHK("ost_ran", 1'b1, osc_seen >= 4)
			check_all;
		end
		// Brown-out, then a second dip while the timer is counting
		brown <= 1'b1;
		cycles(40);
		brown <= 1'b0;
		cycles(12);
		brown <= 1'b1;
		cycles(40);
		rc_seen = 0;
		brown <= 1'b0;
		wait_run;
		`CHK("power_up_timer_rerun", 1'b1, rc_seen >= 8)
		{m_cause, m_to, m_pd} = {3'h5, 1'b1, 1'b1};
		check_all;
		rd_reg(4'h4);
		`CHK("bor_flag", 32'h0000_0000, rv)
		// Brown-out option off: a long dip is ignored
		bor_en <= 1'b0;
		brown <= 1'b1;
		cycles(40);
		`CHK("bor_off", 1'b0, core_rst)
		brown <= 1'b0;
		// RC mode without timer: power-on releases at once
		osc_mode <= 2'h3;
		power_up_timer_en_n <= 1'b1;
		sup <= 1'b0;
		cycles(10);
		`CHK("por_held", 1'b1, core_rst)
		sup <= 1'b1;
		cycles(5);
		`CHK("rc_no_wait", 1'b0, core_rst)
		{m_cause, m_to, m_pd} = {3'h0, 1'b1, 1'b1};
		check_all;
		// Second reset mid-run; preserved contents must survive
		reset_in <= 1'b1;
		cycles(3);
		reset_in <= 1'b0;
		wait_run;
		check_all;
		test_done;
	end
endmodule
